//--- verilog/plsc_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Max link speed reads 0001
// - Max link width reads x1 code
// - ASPM support field reads 11
// - Writable ASPM control, resets to 00
// - Completion boundary bit always reads zero
// - Disable/retrain writable only in reverse mode
// - Negotiated speed reads 2.5 Gb/s code
// - Hot-plug bits set when reverse and enabled
// - Hot-plug bits follow strap at reset
module plsc_regs
  import plsc_pkg::*;
#(
  parameter logic [5:0] MAX_WIDTH = WIDTH_X1,
  parameter logic [7:0] PORT_NUMBER = 8'h00
)(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Mode and strap
  input wire logic reverse_mode,
  input wire logic hotplug_strap,
  // Link trainer status
  input wire logic [5:0] trn_neg_width,
  input wire logic trn_training,
  input wire logic trn_error,
  // Control to link logic
  output logic [1:0] aspm_ctl,
  output logic link_disable,
  output logic retrain_link,
  output logic common_clk_cfg,
  output logic extended_sync
);
  typedef struct packed {
    logic [1:0] aspm;
    logic link_dis;
    logic retrain;
    logic common_clk;
    logic ext_sync;
    logic hp_en;
    logic [5:0] neg_width;
    logic training;
    logic train_err;
    logic [31:0] rdata;
  } plsc_state_t;

  plsc_state_t state_q, state_d;
  logic wr_stb;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic addr_hit;
  logic [31:0] link_cap_w, link_cs_w, slot_cap_w;

  plsc_apb_slave u_apb (
    .clk(clk),
    .reset(reset),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .addr_hit(addr_hit)
  );

  function automatic logic hit(input logic [7:0] a);
    hit = (a == LINK_CAP_OFF) || (a == LINK_CTL_STS_OFF) || (a == SLOT_CAP_OFF);
  endfunction

  function automatic logic ctl_write(input logic stb, input logic [7:0] a, input logic [3:0] s);
    ctl_write = stb && (a == LINK_CTL_STS_OFF) && s[0];
  endfunction

  assign addr_hit = hit(paddr);

  always_comb begin
    link_cap_w = 32'h00000000;
    link_cap_w[MAX_SPEED_LSB +: 4] = SPEED_2G5;
    link_cap_w[MAX_WIDTH_LSB +: 6] = MAX_WIDTH;
    link_cap_w[ASPM_SUP_LSB +: 2] = ASPM_SUP_L0S_L1;
    link_cap_w[L0S_EXIT_LSB +: 3] = L0S_EXIT_RST;
    link_cap_w[L1_EXIT_LSB +: 3] = L1_EXIT_RST;
    link_cap_w[PORT_NUM_LSB +: 8] = PORT_NUMBER;
  end

  always_comb begin
    link_cs_w = 32'h00000000;
    link_cs_w[ASPM_CTL_LSB +: 2] = state_q.aspm;
    link_cs_w[RCB_BIT] = 1'b0;
    link_cs_w[LINK_DIS_BIT] = state_q.link_dis;
    link_cs_w[RETRAIN_BIT] = state_q.retrain;
    link_cs_w[COMMON_CLK_BIT] = state_q.common_clk;
    link_cs_w[EXT_SYNC_BIT] = state_q.ext_sync;
    link_cs_w[LINK_SPEED_LSB +: 4] = SPEED_2G5;
    link_cs_w[NEG_WIDTH_LSB +: 6] = state_q.neg_width;
    link_cs_w[TRAIN_ERR_BIT] = state_q.train_err;
    link_cs_w[TRAINING_BIT] = state_q.training;
    link_cs_w[SLOT_CLK_BIT] = 1'b1;
  end

  always_comb begin
    slot_cap_w = 32'h00000000;
    if (state_q.hp_en && reverse_mode) begin
      slot_cap_w[ATTN_BTN_BIT] = 1'b1;
      slot_cap_w[LATCH_SENSOR_BIT] = 1'b1;
      slot_cap_w[ATTN_IND_BIT] = 1'b1;
      slot_cap_w[PWR_IND_BIT] = 1'b1;
      slot_cap_w[HP_CAPABLE_BIT] = 1'b1;
    end
  end

  always_comb begin
    state_d = state_q;
    // Strap followed every cycle
    state_d.hp_en = hotplug_strap;
    state_d.neg_width = trn_neg_width;
    state_d.training = trn_training;
    state_d.train_err = trn_error;
    if (ctl_write(wr_stb, wr_addr, wr_strb)) begin
      state_d.aspm = wr_data[ASPM_CTL_LSB +: 2];
      state_d.common_clk = wr_data[COMMON_CLK_BIT];
      state_d.ext_sync = wr_data[EXT_SYNC_BIT];
      if (reverse_mode) begin
        state_d.link_dis = wr_data[LINK_DIS_BIT];
        state_d.retrain = wr_data[RETRAIN_BIT];
      end
    end
    unique case (rd_addr)
      LINK_CAP_OFF: state_d.rdata = link_cap_w;
      LINK_CTL_STS_OFF: state_d.rdata = link_cs_w;
      SLOT_CAP_OFF: state_d.rdata = slot_cap_w;
      default: state_d.rdata = 32'h00000000;
    endcase
    if (reset) begin
      state_d = '0;
      state_d.aspm = ASPM_CTL_RST;
      state_d.neg_width = WIDTH_X1;
      state_d.hp_en = hotplug_strap;
    end
  end

  always_ff @(posedge clk) begin
    state_q <= state_d;
  end

  // Read data is registered; valid from the access cycle onward
  assign prdata = state_q.rdata;
  assign aspm_ctl = state_q.aspm;
  assign link_disable = state_q.link_dis;
  assign retrain_link = state_q.retrain;
  assign common_clk_cfg = state_q.common_clk;
  assign extended_sync = state_q.ext_sync;

  property p_max_speed;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CAP_OFF) |-> prdata[3:0] == 4'h1;
  endproperty
  a_max_speed: assert property (p_max_speed) else $error("max speed wrong");

  property p_max_width;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CAP_OFF) |-> prdata[9:4] == MAX_WIDTH;
  endproperty
  a_max_width: assert property (p_max_width) else $error("max width wrong");

  property p_aspm_sup;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CAP_OFF) |-> prdata[11:10] == 2'h3;
  endproperty
  a_aspm_sup: assert property (p_aspm_sup) else $error("aspm support wrong");

  property p_aspm_wr;
    @(posedge clk) disable iff (reset)
      (wr_stb && wr_addr == LINK_CTL_STS_OFF && wr_strb[0]) |=> aspm_ctl == $past(wr_data[1:0]);
  endproperty
  a_aspm_wr: assert property (p_aspm_wr) else $error("aspm control not written");

  property p_aspm_rst;
    @(posedge clk) reset |=> aspm_ctl == 2'h0 && !link_disable && !retrain_link;
  endproperty
  a_aspm_rst: assert property (p_aspm_rst) else $error("control reset wrong");

  property p_rcb;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CTL_STS_OFF) |-> !prdata[3];
  endproperty
  a_rcb: assert property (p_rcb) else $error("boundary bit set");

  property p_fwd_ro;
    @(posedge clk) disable iff (reset)
      !reverse_mode |=> $stable(link_disable) && $stable(retrain_link);
  endproperty
  a_fwd_ro: assert property (p_fwd_ro) else $error("forward mode bits changed");

  property p_speed;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CTL_STS_OFF) |-> prdata[19:16] == 4'h1;
  endproperty
  a_speed: assert property (p_speed) else $error("link speed wrong");

  property p_hp;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == SLOT_CAP_OFF && $past(reset, 2) == 1'b0)
      |-> prdata[6] == ($past(hotplug_strap, 2) && $past(reverse_mode));
  endproperty
  a_hp: assert property (p_hp) else $error("hot-plug bits wrong");

  property p_width;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CTL_STS_OFF && !$past(reset, 2))
      |-> prdata[25:20] == $past(trn_neg_width, 2);
  endproperty
  a_width: assert property (p_width) else $error("width status stale");

  property p_dis_wr;
    @(posedge clk) disable iff (reset)
      (ctl_write(wr_stb, wr_addr, wr_strb) && reverse_mode)
      |=> link_disable == $past(wr_data[LINK_DIS_BIT])
        && retrain_link == $past(wr_data[RETRAIN_BIT]);
  endproperty
  a_dis_wr: assert property (p_dis_wr) else $error("disable or retrain not written");

  property p_aspm_hold;
    @(posedge clk) disable iff (reset)
      !ctl_write(wr_stb, wr_addr, wr_strb) |=> $stable(aspm_ctl);
  endproperty
  a_aspm_hold: assert property (p_aspm_hold) else $error("aspm control changed");

  property p_training;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CTL_STS_OFF
        && !$past(reset) && !$past(reset, 2))
      |-> prdata[TRAINING_BIT] == $past(trn_training, 2)
        && prdata[TRAIN_ERR_BIT] == $past(trn_error, 2);
  endproperty
  a_training: assert property (p_training) else $error("training status stale");

  property p_hp_rst;
    @(posedge clk) reset |=> state_q.hp_en == $past(hotplug_strap);
  endproperty
  a_hp_rst: assert property (p_hp_rst) else $error("hot-plug reset value wrong");

  property p_slot_rsvd;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == SLOT_CAP_OFF)
      |-> (prdata & ~SLOT_CAP_HP_MASK) == 32'h00000000;
  endproperty
  a_slot_rsvd: assert property (p_slot_rsvd) else $error("slot reserved bits set");

  property p_slot_same;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == SLOT_CAP_OFF)
      |-> prdata[ATTN_BTN_BIT] == prdata[HP_CAPABLE_BIT]
        && prdata[LATCH_SENSOR_BIT] == prdata[HP_CAPABLE_BIT]
        && prdata[ATTN_IND_BIT] == prdata[HP_CAPABLE_BIT]
        && prdata[PWR_IND_BIT] == prdata[HP_CAPABLE_BIT];
  endproperty
  a_slot_same: assert property (p_slot_same) else $error("presence bits differ");

  property p_width_rst;
    @(posedge clk) reset |=> state_q.neg_width == WIDTH_X1;
  endproperty
  a_width_rst: assert property (p_width_rst) else $error("width reset wrong");

  property p_rdata_rst;
    @(posedge clk) reset |=> prdata == 32'h00000000;
  endproperty
  a_rdata_rst: assert property (p_rdata_rst) else $error("read data not cleared");

  property p_ctl_rsvd;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CTL_STS_OFF)
      |-> !prdata[2] && prdata[15:8] == 8'h00
        && prdata[31:29] == 3'h0 && prdata[SLOT_CLK_BIT];
  endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control word fixed bits wrong");

  property p_sync_wr;
    @(posedge clk) disable iff (reset)
      ctl_write(wr_stb, wr_addr, wr_strb)
      |=> common_clk_cfg == $past(wr_data[COMMON_CLK_BIT])
        && extended_sync == $past(wr_data[EXT_SYNC_BIT]);
  endproperty
  a_sync_wr: assert property (p_sync_wr) else $error("clock or sync bit not written");

  property p_cap_fixed;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && paddr == LINK_CAP_OFF)
      |-> prdata[31:12] == {PORT_NUMBER, 6'h00, L1_EXIT_RST, L0S_EXIT_RST};
  endproperty
  a_cap_fixed: assert property (p_cap_fixed) else $error("capability fixed fields wrong");

  property p_err_rd;
    @(posedge clk) disable iff (reset)
      (psel && penable && !pwrite && !addr_hit) |-> pslverr && prdata == 32'h00000000;
  endproperty
  a_err_rd: assert property (p_err_rd) else $error("unmapped read not refused");

  c_aspm_wr: cover property (@(posedge clk) wr_stb && wr_addr == LINK_CTL_STS_OFF);
  c_rev_dis: cover property (@(posedge clk) reverse_mode && link_disable);
  c_hp_on: cover property (@(posedge clk) slot_cap_w[6]);
  c_bad_addr: cover property (@(posedge clk) pslverr);
  c_training: cover property (@(posedge clk) state_q.training);
endmodule

//--- include/plsc_pkg.sv
package plsc_pkg;
  // Register byte offsets
  localparam logic [7:0] LINK_CAP_OFF = 8'hBC;
  localparam logic [7:0] LINK_CTL_STS_OFF = 8'hC0;
  localparam logic [7:0] SLOT_CAP_OFF = 8'hC4;
  // Link capability fields and values
  localparam int MAX_SPEED_LSB = 0;
  localparam int MAX_WIDTH_LSB = 4;
  localparam int ASPM_SUP_LSB = 10;
  localparam int L0S_EXIT_LSB = 12;
  localparam int L1_EXIT_LSB = 15;
  localparam int PORT_NUM_LSB = 24;
  localparam logic [3:0] SPEED_2G5 = 4'h1;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [1:0] ASPM_SUP_L0S_L1 = 2'h3;
  localparam logic [2:0] L0S_EXIT_RST = 3'h3;
  localparam logic [2:0] L1_EXIT_RST = 3'h0;
  // Link control fields
  localparam int ASPM_CTL_LSB = 0;
  localparam int RCB_BIT = 3;
  localparam int LINK_DIS_BIT = 4;
  localparam int RETRAIN_BIT = 5;
  localparam int COMMON_CLK_BIT = 6;
  localparam int EXT_SYNC_BIT = 7;
  localparam logic [1:0] ASPM_CTL_RST = 2'h0;
  // Link status fields (in the upper half of the shared word)
  localparam int LINK_SPEED_LSB = 16;
  localparam int NEG_WIDTH_LSB = 20;
  localparam int TRAIN_ERR_BIT = 26;
  localparam int TRAINING_BIT = 27;
  localparam int SLOT_CLK_BIT = 28;
  // Slot capability bits
  localparam int ATTN_BTN_BIT = 0;
  localparam int LATCH_SENSOR_BIT = 2;
  localparam int ATTN_IND_BIT = 3;
  localparam int PWR_IND_BIT = 4;
  localparam int HP_CAPABLE_BIT = 6;
  localparam logic [31:0] SLOT_CAP_HP_MASK = 32'h0000005D;
endpackage

//--- verilog/plsc_apb_slave.sv
`timescale 1ns/1ps
module plsc_apb_slave
  import plsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  // Register side
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [7:0] rd_addr,
  input wire logic addr_hit
);
  // Zero-wait: answer in the first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit;
  assign wr_stb = psel && penable && pwrite && addr_hit;
  assign wr_addr = paddr;
  assign wr_data = pwdata;
  assign wr_strb = pstrb;
  assign rd_addr = paddr;
endmodule

//--- verification/plsc_trainer_model.sv
`timescale 1ns/1ps
module plsc_trainer_model
  import plsc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench request
  input wire logic go,
  input wire logic [5:0] width_req,
  input wire logic err_req,
  // Trainer status
  output logic [5:0] trn_neg_width,
  output logic trn_training,
  output logic trn_error
);
  logic [4:0] cnt_q;
  // Training lasts twenty cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= 5'h00;
      trn_neg_width <= WIDTH_X1;
      trn_training <= 1'b0;
      trn_error <= 1'b0;
    end else if (go) begin
      cnt_q <= 5'h14;
      trn_training <= 1'b1;
    end else if (cnt_q == 5'h01) begin
      cnt_q <= 5'h00;
      trn_training <= 1'b0;
      trn_neg_width <= width_req;
      trn_error <= err_req;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end
  end
endmodule

//--- verification/pcie_link_slot_capability_regs_test.sv
`timescale 1ns/1ps
module pcie_link_slot_capability_regs_test
  import plsc_pkg::*;
();
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, err_req = 1'b0;
  logic reverse_mode = 1'b0, hotplug_strap = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] width_req = 6'h04;
  logic pready, pslverr, trn_training, trn_error, err;
  logic link_disable, retrain_link, common_clk_cfg, extended_sync;
  logic [31:0] prdata, rd;
  logic [5:0] trn_neg_width;
  logic [1:0] aspm_ctl;
  int n_mismatch = 0;
  int checks_done = 0;
  localparam logic [31:0] CAP = {8'h00, 6'h00, 3'h0, 3'h3, 2'h3, 6'h01, 4'h1};

  initial forever #50 clk = ~clk;

  plsc_regs DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .reverse_mode(reverse_mode),
    .hotplug_strap(hotplug_strap), .trn_neg_width(trn_neg_width),
    .trn_training(trn_training), .trn_error(trn_error), .aspm_ctl(aspm_ctl),
    .link_disable(link_disable), .retrain_link(retrain_link),
    .common_clk_cfg(common_clk_cfg), .extended_sync(extended_sync));

  plsc_trainer_model MODEL (.clk(clk), .reset(reset), .go(go), .width_req(width_req),
    .err_req(err_req), .trn_neg_width(trn_neg_width), .trn_training(trn_training),
    .trn_error(trn_error));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
  endtask

  task automatic t_reset_values();
    apb(1'b1, LINK_CAP_OFF, 32'hFFFFFFFF);
    apb(1'b0, LINK_CAP_OFF, 32'h0);
    chk("link_capability", CAP, rd);
    chk("mapped_err", 32'h0, {31'h0, err});
    apb(1'b0, LINK_CTL_STS_OFF, 32'h0);
    chk("link_ctl_sts", 32'h10110000, rd);
    apb(1'b0, SLOT_CAP_OFF, 32'h0);
    chk("slot_capability", 32'h00000000, rd);
  endtask

  task automatic t_aspm();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, LINK_CTL_STS_OFF, 32'(i));
      apb(1'b0, LINK_CTL_STS_OFF, 32'h0);
      chk("link_control", 32'(i), {16'h0, rd[15:0]});
      chk("aspm_ctl", 32'(i), {30'h0, aspm_ctl});
    end
    pstrb <= 4'hE;
    apb(1'b1, LINK_CTL_STS_OFF, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, LINK_CTL_STS_OFF, 32'h0);
    chk("aspm_ctl", 32'h3, {30'h0, aspm_ctl});
  endtask

  task automatic t_mode_bits(input logic rev, input logic [31:0] exp);
    reverse_mode <= rev;
    apb(1'b1, LINK_CTL_STS_OFF, 32'h000000FF);
    apb(1'b0, LINK_CTL_STS_OFF, 32'h0);
    chk("link_control", exp, {16'h0, rd[15:0]});
    chk("dis_retrain", {30'h0, exp[4], exp[4]}, {30'h0, link_disable, retrain_link});
    chk("clk_sync", {30'h0, exp[7], exp[6]}, {30'h0, extended_sync, common_clk_cfg});
    apb(1'b1, LINK_CTL_STS_OFF, 32'h0);
  endtask

  task automatic t_hotplug();
    for (int i = 0; i < 4; i++) begin
      {hotplug_strap, reverse_mode} <= 2'(i);
      apb(1'b0, SLOT_CAP_OFF, 32'h0);
      chk("slot_capability", (i == 3) ? 32'h0000005D : 32'h0, rd);
    end
    reset <= 1'b1;
    repeat (19) @(posedge clk);
    // Release and first setup share one edge
    fork
      begin
        @(posedge clk);
        reset <= 1'b0;
      end
      apb(1'b0, SLOT_CAP_OFF, 32'h0);
    join
    chk("slot_capability", 32'h0000005D, rd);
  endtask

  task automatic t_trainer();
    err_req <= 1'b1;
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    apb(1'b0, LINK_CTL_STS_OFF, 32'h0);
    chk("link_status", 32'h1811, {16'h0, rd[31:16]});
    repeat (30) @(posedge clk);
    apb(1'b0, LINK_CTL_STS_OFF, 32'h0);
    chk("link_status", 32'h1441, {16'h0, rd[31:16]});
  endtask

  task automatic t_unmapped();
    apb(1'b0, 8'hB8, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, rd);
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    do_reset();
    t_reset_values();
    t_aspm();
    t_mode_bits(1'b0, 32'h000000C3);
    t_mode_bits(1'b1, 32'h000000F3);
    t_trainer();
    t_unmapped();
    t_hotplug();
    wrap_up();
  end
endmodule
